// >>> src/eiu_ext_pin_irq.sv
// Top of the external pin interrupt unit: registers, flags, requests.
// Assumes the CPU register port and dispatcher run on mclk.
//
// Function
// - Any enabled toggle in bank 23:16, 14:8 or 7:0 raises request 4, 3, 2.
// - Pins fire even when driven as outputs, giving software interrupts.
// - Pin changes are seen without a clock to wake from deep sleep.
// - Enabled level mode requests for as long as the pin stays low.
// - Dedicated pin edges are detected only while the I/O clock runs.
// - A low level on a dedicated pin is seen without a clock.
// - A level gone before start-up ends wakes but raises no interrupt.
// - Sense codes: 00 low, 01 any change, 10 falling, 11 rising.
// - Pin 1 sense in bits 3:2, pin 0 in 1:0; needs global and mask.
// - Pin is sampled before edge detection; pulses over one clock fire.
// - Mask bit 1 enables pin 1, bit 0 pin 0; each has own vector.
// - Pin flag sets on edge, clears on service entry or written one.
// - In level mode a pin flag reads as cleared.
// - Bank enables 2:0 gate bank requests with the global flag.
// - Bank flags sit in bits 2:0 of the flag register, reset zero.
// - Low registers also answer at data offset minus 0x20 over I/O.
// - Bank flag sets on enabled change, clears on service or written one.
// - A bank mask bit enables its pin only while the bank is enabled.
`default_nettype none

module eiu_ext_pin_irq (
  // Clock and reset.
  input  wire logic                 mclk,
  input  wire logic                 rst,
  // External pins.
  input  wire logic                 extIrqPinZero,
  input  wire logic                 extIrqPinOne,
  input  wire logic [23:0]          changeWatchInput,
  // CPU side.
  input  wire logic                 statusIntEnable,
  input  wire eiu_pkg::eiu_bus_type regBus,
  input  wire eiu_pkg::eiu_ack_type ack,
  output logic [7:0]                rdData,
  output logic [4:0]                irqRequest,
  // Clockless wake to the power manager.
  output logic                      wakeRequest
);

  // Registers.
  logic [1:0] mask_ff;
  logic [3:0] sense_ff;
  logic [2:0] bankEn_ff;
  logic [7:0] bankMask0_ff;
  logic [6:0] bankMask1_ff;
  logic [7:0] bankMask2_ff;
  logic [1:0] pinFlags_ff;
  logic [2:0] bankFlags_ff;
  logic [7:0] rdData_ff;
  logic [4:0] irq_ff;
  logic [1:0] nxt_mask;
  logic [3:0] nxt_sense;
  logic [2:0] nxt_bankEn;
  logic [7:0] nxt_bankMask0;
  logic [6:0] nxt_bankMask1;
  logic [7:0] nxt_bankMask2;
  logic [1:0] nxt_pinFlags;
  logic [2:0] nxt_bankFlags;
  logic [7:0] nxt_rdData;
  logic [4:0] nxt_irq;

  // Decode and detector results.
  logic [7:0]                  effAddr;
  logic [1:0]                  pinVec;
  logic [1:0]                  levelMode;
  logic [1:0]                  levelLow;
  logic [1:0]                  pinEdge;
  logic [1:0]                  asyncLow;
  logic [1:0]                  pinClr;
  logic [2:0]                  bankHit;
  logic [2:0]                  bankAsync;
  logic [2:0]                  bankClr;
  eiu_pkg::eiu_sense_type      senseSel [eiu_pkg::PIN_NUM];

  ////////////////////////////////////////////////////////////////
  // I/O accesses are moved up into data space before decode.
  assign effAddr = regBus.isIo ? ({2'b00, regBus.addr[5:0]} + eiu_pkg::IO_SHIFT) : regBus.addr;

  assign pinVec      = {extIrqPinOne, extIrqPinZero};
  assign senseSel[0] = eiu_pkg::eiu_sense_type'(sense_ff[eiu_pkg::SENSE0_LSB +: eiu_pkg::SENSE_W]);
  assign senseSel[1] = eiu_pkg::eiu_sense_type'(sense_ff[eiu_pkg::SENSE1_LSB +: eiu_pkg::SENSE_W]);

  ////////////////////////////////////////////////////////////////
  // One sense block per dedicated pin. There is no direction input:
  // the pad level is watched whether or not the port drives it.
  for (genvar p = 0; p < eiu_pkg::PIN_NUM; p++) begin : g_sense
    assign levelMode[p] = (senseSel[p] == eiu_pkg::SENSE_LOW);

    eiu_pin_sense u_sense (
      .mclk     (mclk),
      .rst      (rst),
      .pinRaw   (pinVec[p]),
      .sense    (senseSel[p]),
      .levelLow (levelLow[p]),
      .edgeHit  (pinEdge[p]),
      .asyncLow (asyncLow[p])
    );
  end

  ////////////////////////////////////////////////////////////////
  // Bank watchers; input 15 has no mask bit and is never watched.
  eiu_bank_watch #(.WIDTH(eiu_pkg::BANK0_W)) u_bank0 (
    .mclk        (mclk),
    .rst         (rst),
    .pinsRaw     (changeWatchInput[7:0]),
    .mask        (bankMask0_ff),
    .enable      (bankEn_ff[0]),
    .changeHit   (bankHit[0]),
    .asyncChange (bankAsync[0])
  );

  eiu_bank_watch #(.WIDTH(eiu_pkg::BANK1_W)) u_bank1 (
    .mclk        (mclk),
    .rst         (rst),
    .pinsRaw     (changeWatchInput[14:8]),
    .mask        (bankMask1_ff),
    .enable      (bankEn_ff[1]),
    .changeHit   (bankHit[1]),
    .asyncChange (bankAsync[1])
  );

  eiu_bank_watch #(.WIDTH(eiu_pkg::BANK2_W)) u_bank2 (
    .mclk        (mclk),
    .rst         (rst),
    .pinsRaw     (changeWatchInput[23:16]),
    .mask        (bankMask2_ff),
    .enable      (bankEn_ff[2]),
    .changeHit   (bankHit[2]),
    .asyncChange (bankAsync[2])
  );

  ////////////////////////////////////////////////////////////////
  // Clockless wake: kept off the clocked request path on purpose, so a
  // level gone before start-up ends leaves no request behind.
  assign wakeRequest = (|(asyncLow & mask_ff & levelMode)) | (|bankAsync);

  ////////////////////////////////////////////////////////////////
  // Control registers written by software.
  always_comb begin
    nxt_mask      = mask_ff;
    nxt_sense     = sense_ff;
    nxt_bankEn    = bankEn_ff;
    nxt_bankMask0 = bankMask0_ff;
    nxt_bankMask1 = bankMask1_ff;
    nxt_bankMask2 = bankMask2_ff;
    if (regBus.wrEn) begin
      case (effAddr)
        eiu_pkg::OFS_EXT_MASK:   nxt_mask      = regBus.wdata[1:0];
        eiu_pkg::OFS_SENSE:      nxt_sense     = regBus.wdata[3:0];
        eiu_pkg::OFS_PC_CTRL:    nxt_bankEn    = regBus.wdata[2:0];
        eiu_pkg::OFS_BANK0_MASK: nxt_bankMask0 = regBus.wdata;
        eiu_pkg::OFS_BANK1_MASK: nxt_bankMask1 = regBus.wdata[6:0];
        eiu_pkg::OFS_BANK2_MASK: nxt_bankMask2 = regBus.wdata;
        default:                 nxt_mask      = mask_ff;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mask_ff      <= eiu_pkg::RST_REG[1:0];
      sense_ff     <= eiu_pkg::RST_REG[3:0];
      bankEn_ff    <= eiu_pkg::RST_REG[2:0];
      bankMask0_ff <= eiu_pkg::RST_REG;
      bankMask1_ff <= eiu_pkg::RST_REG[6:0];
      bankMask2_ff <= eiu_pkg::RST_REG;
    end else begin
      mask_ff      <= nxt_mask;
      sense_ff     <= nxt_sense;
      bankEn_ff    <= nxt_bankEn;
      bankMask0_ff <= nxt_bankMask0;
      bankMask1_ff <= nxt_bankMask1;
      bankMask2_ff <= nxt_bankMask2;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Flags: a new event beats a clear in the same cycle.
  always_comb begin
    pinClr  = '0;
    bankClr = '0;
    if (regBus.wrEn && effAddr == eiu_pkg::OFS_EXT_FLAGS) begin
      pinClr = regBus.wdata[1:0];
    end
    if (regBus.wrEn && effAddr == eiu_pkg::OFS_PC_FLAGS) begin
      bankClr = regBus.wdata[2:0];
    end
    if (ack.ack) begin
      case (ack.vec)
        eiu_pkg::VEC_PIN0:  pinClr[0]  = 1'b1;
        eiu_pkg::VEC_PIN1:  pinClr[1]  = 1'b1;
        eiu_pkg::VEC_BANK0: bankClr[0] = 1'b1;
        eiu_pkg::VEC_BANK1: bankClr[1] = 1'b1;
        eiu_pkg::VEC_BANK2: bankClr[2] = 1'b1;
        default:            pinClr     = pinClr;
      endcase
    end
    nxt_pinFlags  = (pinEdge | (pinFlags_ff & ~pinClr)) & ~levelMode;
    nxt_bankFlags = bankHit | (bankFlags_ff & ~bankClr);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pinFlags_ff  <= eiu_pkg::RST_REG[1:0];
      bankFlags_ff <= eiu_pkg::RST_REG[2:0];
    end else begin
      pinFlags_ff  <= nxt_pinFlags;
      bankFlags_ff <= nxt_bankFlags;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Requests, one per vector, all gated by the global flag. A level
  // request follows the synced pin and so drops when the pin rises.
  always_comb begin
    for (int p = 0; p < eiu_pkg::PIN_NUM; p++) begin
      nxt_irq[p] = statusIntEnable & mask_ff[p] &
                   (levelMode[p] ? levelLow[p] : pinFlags_ff[p]);
    end
    for (int b = 0; b < eiu_pkg::BANK_NUM; b++) begin
      nxt_irq[eiu_pkg::PIN_NUM + b] = statusIntEnable & bankEn_ff[b] & bankFlags_ff[b];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read data, one cycle after the read strobe; unmapped reads give 0.
  always_comb begin
    nxt_rdData = rdData_ff;
    if (regBus.rdEn) begin
      case (effAddr)
        eiu_pkg::OFS_PC_FLAGS:   nxt_rdData = {5'h00, bankFlags_ff};
        eiu_pkg::OFS_EXT_FLAGS:  nxt_rdData = {6'h00, pinFlags_ff & ~levelMode};
        eiu_pkg::OFS_EXT_MASK:   nxt_rdData = {6'h00, mask_ff};
        eiu_pkg::OFS_PC_CTRL:    nxt_rdData = {5'h00, bankEn_ff};
        eiu_pkg::OFS_SENSE:      nxt_rdData = {4'h0, sense_ff};
        eiu_pkg::OFS_BANK0_MASK: nxt_rdData = bankMask0_ff;
        eiu_pkg::OFS_BANK1_MASK: nxt_rdData = {1'b0, bankMask1_ff};
        eiu_pkg::OFS_BANK2_MASK: nxt_rdData = bankMask2_ff;
        default:                 nxt_rdData = eiu_pkg::RST_REG;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdData_ff <= eiu_pkg::RST_REG;
      irq_ff    <= '0;
    end else begin
      rdData_ff <= nxt_rdData;
      irq_ff    <= nxt_irq;
    end
  end

  assign rdData     = rdData_ff;
  assign irqRequest = irq_ff;

  ////////////////////////////////////////////////////////////////
  // Checks on the flag, request and decode behaviour.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence lowHeld;
    statusIntEnable && mask_ff[0] && levelMode[0] && levelLow[0];
  endsequence

  sequence flagWriteOne;
    regBus.wrEn && effAddr == eiu_pkg::OFS_EXT_FLAGS && regBus.wdata[0] && !pinEdge[0];
  endsequence

  a_edge_sets_flag: assert property (
    pinEdge[0] |=> pinFlags_ff[0]) else $error("Edge did not set pin flag");

  a_level_flag_zero: assert property (
    levelMode[1] |=> !pinFlags_ff[1]) else $error("Pin flag set in level mode");

  a_flag_write_clear: assert property (
    flagWriteOne |=> !pinFlags_ff[0]) else $error("Written one did not clear");

  a_set_beats_clear: assert property (
    (bankClr[0] && bankHit[0]) |=> bankFlags_ff[0]) else $error("Clear beat set");

  a_level_request: assert property (
    lowHeld ##1 lowHeld |=> irq_ff[0]) else $error("Level request dropped");

  a_bank_gate: assert property (
    irq_ff[2] |-> $past(bankEn_ff[0] && statusIntEnable && bankFlags_ff[0]))
    else $error("Bank request without enable");

  a_io_alias: assert property (
    (regBus.wrEn && regBus.isIo && regBus.addr[5:0] == 6'(eiu_pkg::OFS_EXT_MASK - eiu_pkg::IO_SHIFT))
    |=> mask_ff == $past(regBus.wdata[1:0])) else $error("I/O alias write lost");

  a_ack_clear: assert property (
    (ack.ack && ack.vec == eiu_pkg::VEC_BANK2 && !bankHit[2]) |=> !bankFlags_ff[2] ##1 !irq_ff[4])
    else $error("Service entry did not clear");

endmodule : eiu_ext_pin_irq

`default_nettype wire

// >>> src/eiu_pkg.sv
// Shared constants and types of the external pin interrupt unit.
// Assumes one 25 MHz clock and the CPU's data-space register port.
`default_nettype none

package eiu_pkg;

  // Data-space register offsets.
  localparam logic [7:0] OFS_PC_FLAGS   = 8'h3B;
  localparam logic [7:0] OFS_EXT_FLAGS  = 8'h3C;
  localparam logic [7:0] OFS_EXT_MASK   = 8'h3D;
  localparam logic [7:0] OFS_PC_CTRL    = 8'h68;
  localparam logic [7:0] OFS_SENSE      = 8'h69;
  localparam logic [7:0] OFS_BANK0_MASK = 8'h6B;
  localparam logic [7:0] OFS_BANK1_MASK = 8'h6C;
  localparam logic [7:0] OFS_BANK2_MASK = 8'h6D;

  // I/O instructions see low registers shifted down by this amount.
  localparam logic [7:0] IO_SHIFT = 8'h20;

  // Reset values.
  localparam logic [7:0] RST_REG  = 8'h00;
  localparam logic       PIN_IDLE = 1'b1;

  // Field positions of the sense control register.
  localparam int SENSE0_LSB = 0;
  localparam int SENSE1_LSB = 2;
  localparam int SENSE_W    = 2;

  // Counts of sources and bank widths.
  localparam int PIN_NUM   = 2;
  localparam int BANK_NUM  = 3;
  localparam int BANK0_W   = 8;
  localparam int BANK1_W   = 7;
  localparam int BANK2_W   = 8;
  localparam int IRQ_NUM   = 5;

  // Vector indices of the five requests.
  localparam logic [2:0] VEC_PIN0  = 3'h0;
  localparam logic [2:0] VEC_PIN1  = 3'h1;
  localparam logic [2:0] VEC_BANK0 = 3'h2;
  localparam logic [2:0] VEC_BANK1 = 3'h3;
  localparam logic [2:0] VEC_BANK2 = 3'h4;

  // Trigger selections of a dedicated pin.
  typedef enum logic [1:0] {
    SENSE_LOW  = 2'b00,
    SENSE_ANY  = 2'b01,
    SENSE_FALL = 2'b10,
    SENSE_RISE = 2'b11
  } eiu_sense_type;

  // One register access from the CPU.
  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic       isIo;
    logic [7:0] addr;
    logic [7:0] wdata;
  } eiu_bus_type;

  // Entry of a service routine, from the dispatcher.
  typedef struct packed {
    logic       ack;
    logic [2:0] vec;
  } eiu_ack_type;

endpackage : eiu_pkg

`default_nettype wire

// >>> src/eiu_pin_sense.sv
// Sense logic of one dedicated interrupt pin.
// Assumes the pin level is sampled on mclk, the I/O clock.
`default_nettype none

module eiu_pin_sense (
  // Clock and reset.
  input  wire logic                   mclk,
  input  wire logic                   rst,
  // Pin and mode.
  input  wire logic                   pinRaw,
  input  wire eiu_pkg::eiu_sense_type sense,
  // Results.
  output logic                        levelLow,
  output logic                        edgeHit,
  output logic                        asyncLow
);

  logic meta_ff;
  logic sync_ff;
  logic prev_ff;
  logic nxt_meta;
  logic nxt_sync;
  logic nxt_prev;

  ////////////////////////////////////////////////////////////////
  // Two-stage synchroniser and one history stage.
  always_comb begin
    nxt_meta = pinRaw;
    nxt_sync = meta_ff;
    nxt_prev = sync_ff;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_ff <= eiu_pkg::PIN_IDLE;
      sync_ff <= eiu_pkg::PIN_IDLE;
      prev_ff <= eiu_pkg::PIN_IDLE;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      prev_ff <= nxt_prev;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Edges are found only on sampled values, so they need the clock.
  always_comb begin
    case (sense)
      eiu_pkg::SENSE_ANY:  edgeHit = sync_ff ^ prev_ff;
      eiu_pkg::SENSE_FALL: edgeHit = prev_ff & ~sync_ff;
      eiu_pkg::SENSE_RISE: edgeHit = ~prev_ff & sync_ff;
      default:             edgeHit = 1'b0;
    endcase
  end

  // The raw low level wakes the part with no clock at all.
  assign asyncLow = ~pinRaw;
  assign levelLow = ~sync_ff;

  sequence riseSeen;
    (sense == eiu_pkg::SENSE_RISE) && $rose(sync_ff);
  endsequence

  a_rise_detect: assert property (@(posedge mclk) disable iff (rst)
    riseSeen |-> edgeHit) else $error("Rising edge missed");

  a_level_no_edge: assert property (@(posedge mclk) disable iff (rst)
    (sense == eiu_pkg::SENSE_LOW) |-> !edgeHit) else $error("Edge in level mode");

endmodule : eiu_pin_sense

`default_nettype wire

// >>> src/eiu_bank_watch.sv
// Change watcher of one bank of pin-change inputs.
// Assumes the inputs are sampled on mclk; the wake output is clockless.
`default_nettype none

module eiu_bank_watch #(
  parameter int WIDTH = 8
) (
  // Clock and reset.
  input  wire logic             mclk,
  input  wire logic             rst,
  // Pins and enables.
  input  wire logic [WIDTH-1:0] pinsRaw,
  input  wire logic [WIDTH-1:0] mask,
  input  wire logic             enable,
  // Results.
  output logic                  changeHit,
  output logic                  asyncChange
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] prev_ff;
  logic [WIDTH-1:0] toggled;
  logic [WIDTH-1:0] rawDiff;

  ////////////////////////////////////////////////////////////////
  // Three stages per pin; the first is read only by the second.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta_ff <= {WIDTH{eiu_pkg::PIN_IDLE}};
      sync_ff <= {WIDTH{eiu_pkg::PIN_IDLE}};
      prev_ff <= {WIDTH{eiu_pkg::PIN_IDLE}};
    end else begin
      meta_ff <= pinsRaw;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Per pin: a masked toggle, and a raw mismatch for clockless wake.
  for (genvar i = 0; i < WIDTH; i++) begin : g_pin
    assign toggled[i] = mask[i] & (sync_ff[i] ^ prev_ff[i]);
    assign rawDiff[i] = mask[i] & (pinsRaw[i] ^ sync_ff[i]);
  end

  // With the clock stopped the synced copy freezes, so any change shows.
  assign changeHit   = enable & (|toggled);
  assign asyncChange = enable & (|rawDiff);

  a_mask_blocks: assert property (@(posedge mclk) disable iff (rst)
    (mask == '0) |-> !changeHit && !asyncChange) else $error("Masked pin fired");

endmodule : eiu_bank_watch

`default_nettype wire

// >>> verif/eiu_dispatch_model.sv
// Behavioural model of the CPU interrupt dispatcher that serves the unit's requests.
// Assumes requests settle before the falling edge of mclk; acks are driven there for one cycle.
`default_nettype none

module eiu_dispatch_model (
  // Clock and reset.
  input  wire logic                 mclk,
  input  wire logic                 rst,
  // Requests and bench controls.
  input  wire logic [4:0]           irqRequest,
  input  wire logic                 ackOn,
  input  wire logic [3:0]           ackDelay,
  // Service routine entry.
  output var  eiu_pkg::eiu_ack_type ack
);
  timeunit 1ns;
  timeprecision 1ns;

  int   waitCnt;
  int   vecIdx;
  logic fire;

  //////////////////////////////////////////////////////////////////////////////
  // Serve the lowest pending request after the set delay, then rest four cycles.
  // The rest is needed because a served request drops only two cycles after the ack.
  always @(negedge mclk) begin
    fire   = 1'b0;
    vecIdx = 0;
    if (waitCnt < 0) begin
      waitCnt <= waitCnt + 1;
    end else if (rst || !ackOn || irqRequest == 5'h00) begin
      waitCnt <= 0;
    end else if (waitCnt < int'(ackDelay)) begin
      waitCnt <= waitCnt + 1;
    end else begin
      fire = 1'b1;
      while (!irqRequest[vecIdx]) vecIdx++;
      waitCnt <= -4;
    end
    ack.ack <= fire;
    if (fire) ack.vec <= 3'(vecIdx);
  end
endmodule : eiu_dispatch_model

`default_nettype wire

// >>> verif/eiu_ext_pin_irq_bench.sv
// Self-checking bench of the external pin interrupt unit, using register tasks.
// Assumes the dispatcher model beside it; all inputs change at the falling edge.
`default_nettype none

module eiu_ext_pin_irq_bench;
  timeunit 1ns;
  timeprecision 1ns;

  logic                 mclk;
  logic                 rst;
  logic                 pin0;
  logic                 pin1;
  logic [23:0]          watchIn;
  logic                 intEn;
  eiu_pkg::eiu_bus_type regBus;
  eiu_pkg::eiu_ack_type ack;
  logic [7:0]           rdData;
  logic [4:0]           irqRequest;
  logic                 wakeRequest;
  logic                 ackOn;
  logic [3:0]           ackDelay;
  int                   error_cnt;
  int                   compares;
  int                   pinIdx[3] = '{0, 8, 23};

  //////////////////////////////////////////////////////////////////////////////
  // Device and far side.
  eiu_ext_pin_irq i_eiu_ext_pin_irq (
    .mclk(mclk), .rst(rst), .extIrqPinZero(pin0), .extIrqPinOne(pin1), .changeWatchInput(watchIn),
    .statusIntEnable(intEn), .regBus(regBus), .ack(ack), .rdData(rdData), .irqRequest(irqRequest),
    .wakeRequest(wakeRequest));
  eiu_dispatch_model i_eiu_dispatch_model (
    .mclk(mclk), .rst(rst), .irqRequest(irqRequest), .ackOn(ackOn), .ackDelay(ackDelay), .ack(ack));

  //////////////////////////////////////////////////////////////////////////////
  // Clock at 25 MHz, and a watchdog so a hang still reaches the verdict.
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  initial begin
    #2000000;
    error_cnt++;
    report_and_stop();
  end

  //////////////////////////////////////////////////////////////////////////////
  // Shared tasks.
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc

  task automatic wr(input logic io, input logic [7:0] addr, input logic [7:0] data);
    @(negedge mclk);
    regBus <= '{wrEn: 1'b1, rdEn: 1'b0, isIo: io, addr: addr, wdata: data};
    @(negedge mclk);
    regBus <= '0;
  endtask : wr

  // The read data holds until the next read, so it is sampled a full cycle late.
  task automatic rd(input logic io, input logic [7:0] addr, input logic [7:0] exp, input string what);
    @(negedge mclk);
    regBus <= '{wrEn: 1'b0, rdEn: 1'b1, isIo: io, addr: addr, wdata: 8'h00};
    @(negedge mclk);
    regBus <= '0;
    @(negedge mclk);
    check(what, rdData, exp);
  endtask : rd

  task automatic wait_irq(input int idx, input logic lvl);
    int n;
    n = 0;
    while (irqRequest[idx] !== lvl && n < 20) begin
      @(negedge mclk);
      n++;
    end
    if (irqRequest[idx] !== lvl) begin
      error_cnt++;
      report_and_stop();
    end
    check("irqRequest", {7'h00, irqRequest[idx]}, {7'h00, lvl});
  endtask : wait_irq

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : report_and_stop

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    rst = 1'b1; pin0 = 1'b1; pin1 = 1'b1; watchIn = '0; intEn = 1'b0;
    regBus = '0; ackOn = 1'b0; ackDelay = 4'h0; error_cnt = 0; compares = 0;
    cyc(12);
    rst <= 1'b0;
    // Reset values, an unmapped place and the I/O alias with reserved bits.
    rd(0, eiu_pkg::OFS_PC_FLAGS, 8'h00, "pin_change_flags");
    rd(0, eiu_pkg::OFS_EXT_FLAGS, 8'h00, "ext_pin_flags");
    rd(0, eiu_pkg::OFS_EXT_MASK, 8'h00, "ext_pin_mask");
    rd(0, eiu_pkg::OFS_PC_CTRL, 8'h00, "pin_change_control");
    rd(0, 8'h50, 8'h00, "unmapped");
    wr(1, 8'h1D, 8'hFF);
    rd(0, eiu_pkg::OFS_EXT_MASK, 8'h03, "ext_pin_mask");
    rd(1, 8'h1D, 8'h03, "ext_pin_mask alias");
    // Each edge code in both fields: a fall, then a rise, with the flag cleared between.
    for (int code = 1; code < 4; code++) begin
      wr(0, eiu_pkg::OFS_SENSE, 8'(code * 5));
      wr(0, eiu_pkg::OFS_EXT_FLAGS, 8'h03);
      pin0 <= 1'b0;
      pin1 <= 1'b0;
      cyc(6);
      rd(1, 8'h1C, (code == 3) ? 8'h00 : 8'h03, "ext_pin_flags after fall");
      wr(1, 8'h1C, 8'h03);
      pin0 <= 1'b1;
      pin1 <= 1'b1;
      cyc(6);
      rd(1, 8'h1C, (code == 2) ? 8'h00 : 8'h03, "ext_pin_flags after rise");
    end
    // A two-cycle pulse is caught; the request waits for the global flag, then an ack clears it.
    wr(0, eiu_pkg::OFS_EXT_FLAGS, 8'h03);
    pin0 <= 1'b0;
    cyc(2);
    pin0 <= 1'b1;
    cyc(6);
    check("irqRequest without global flag", {3'h0, irqRequest}, 8'h00);
    intEn <= 1'b1;
    wait_irq(0, 1'b1);
    check("irqRequest pin one", {7'h00, irqRequest[1]}, 8'h00);
    ackOn <= 1'b1;
    ackDelay <= 4'h3;
    wait_irq(0, 1'b0);
    rd(0, eiu_pkg::OFS_EXT_FLAGS, 8'h00, "ext_pin_flags after ack");
    ackOn <= 1'b0;
    // With its mask bit clear, pin one sets its flag but raises no request.
    wr(0, eiu_pkg::OFS_EXT_MASK, 8'h01);
    pin1 <= 1'b0;
    cyc(2);
    pin1 <= 1'b1;
    cyc(6);
    check("irqRequest masked", {7'h00, irqRequest[1]}, 8'h00);
    rd(0, eiu_pkg::OFS_EXT_FLAGS, 8'h02, "ext_pin_flags masked");
    wr(0, eiu_pkg::OFS_EXT_FLAGS, 8'h02);
    rd(0, eiu_pkg::OFS_EXT_FLAGS, 8'h00, "ext_pin_flags cleared");
    // Level mode on pin zero: the source holds the pin low well past any instruction.
    wr(0, eiu_pkg::OFS_SENSE, 8'h0C);
    pin0 <= 1'b0;
    #1 check("wakeRequest level", {7'h00, wakeRequest}, 8'h01);
    wait_irq(0, 1'b1);
    cyc(20);
    check("irqRequest level held", {7'h00, irqRequest[0]}, 8'h01);
    rd(0, eiu_pkg::OFS_EXT_FLAGS, 8'h00, "ext_pin_flags level");
    pin0 <= 1'b1;
    wait_irq(0, 1'b0);
    check("wakeRequest idle", {7'h00, wakeRequest}, 8'h00);
    // Banks: one masked toggle each, seen unclocked, flagged, then cleared by a written one.
    wr(0, eiu_pkg::OFS_PC_CTRL, 8'hFF);
    rd(0, eiu_pkg::OFS_PC_CTRL, 8'h07, "pin_change_control");
    wr(0, eiu_pkg::OFS_BANK0_MASK, 8'h01);
    wr(0, eiu_pkg::OFS_BANK1_MASK, 8'hFF);
    rd(0, eiu_pkg::OFS_BANK1_MASK, 8'h7F, "bank1_pin_mask");
    wr(0, eiu_pkg::OFS_BANK2_MASK, 8'h80);
    for (int b = 0; b < 3; b++) begin
      watchIn[pinIdx[b]] <= ~watchIn[pinIdx[b]];
      #1 check("wakeRequest change", {7'h00, wakeRequest}, 8'h01);
      wait_irq(2 + b, 1'b1);
      rd(0, eiu_pkg::OFS_PC_FLAGS, 8'(1 << b), "pin_change_flags");
      wr(1, 8'h1B, 8'(1 << b));
      wait_irq(2 + b, 1'b0);
    end
    // An unmasked pin and a disabled bank both stay silent.
    watchIn[1] <= 1'b1;
    cyc(6);
    rd(0, eiu_pkg::OFS_PC_FLAGS, 8'h00, "pin_change_flags unmasked");
    wr(0, eiu_pkg::OFS_PC_CTRL, 8'h06);
    watchIn[0] <= ~watchIn[0];
    cyc(6);
    rd(0, eiu_pkg::OFS_PC_FLAGS, 8'h00, "pin_change_flags disabled");
    // A prompt dispatcher clears the bank two flag on service entry.
    wr(0, eiu_pkg::OFS_PC_CTRL, 8'h07);
    // A written one in the very cycle of a new change loses to the change.
    watchIn[0] <= ~watchIn[0];
    cyc(1);
    wr(1, 8'h1B, 8'h01);
    rd(0, eiu_pkg::OFS_PC_FLAGS, 8'h01, "pin_change_flags set beats clear");
    wr(0, eiu_pkg::OFS_PC_FLAGS, 8'h01);
    ackOn <= 1'b1;
    ackDelay <= 4'h0;
    watchIn[23] <= ~watchIn[23];
    wait_irq(4, 1'b1);
    wait_irq(4, 1'b0);
    rd(0, eiu_pkg::OFS_PC_FLAGS, 8'h00, "pin_change_flags after ack");
    report_and_stop();
  end
endmodule : eiu_ext_pin_irq_bench

`default_nettype wire
